// file: tb/bcdmu_top_test.sv
// bcdmu_top_test: self-checking bench, apb and instruction port calls
// assumes: design files and bcdmu_cfg.svh are compiled ahead of it
`timescale 1ns/1ps
`include "bcdmu_cfg.svh"
module bcdmu_top_test;
  localparam logic [9:0] LT = 10'h001 << `BCDMU_F_LT;
  localparam logic [9:0] EQ = 10'h001 << `BCDMU_F_EQ;
  localparam logic [9:0] GT = 10'h001 << `BCDMU_F_GT;
  localparam logic [9:0] ZR = 10'h001 << `BCDMU_F_ZERO;
  localparam logic [9:0] CW = 10'h001 << `BCDMU_F_CY_W;
  localparam logic [9:0] CD = 10'h001 << `BCDMU_F_CY_D;
  localparam logic [9:0] BW = 10'h001 << `BCDMU_F_BR_W;
  localparam logic [9:0] BD = 10'h001 << `BCDMU_F_BR_D;
  localparam logic [9:0] NG = 10'h001 << `BCDMU_F_NEG;
  localparam logic [9:0] BAD = 10'h001 << `BCDMU_F_BAD;
  localparam logic [7:0] AO = `BCDMU_ACC_OFS;
  localparam logic [7:0] FO = `BCDMU_FLAG_OFS;
  localparam logic [7:0] SO = `BCDMU_STAT_OFS;
  localparam logic [7:0] MO = `BCDMU_MASK_OFS;
  localparam bcdmu_pkg::bcdmu_op_t WC = bcdmu_pkg::word_relation_op;
  localparam bcdmu_pkg::bcdmu_op_t DC = bcdmu_pkg::dword_relation_op;
  localparam bcdmu_pkg::bcdmu_op_t WA = bcdmu_pkg::bcd_sum_word_op;
  localparam bcdmu_pkg::bcdmu_op_t DA = bcdmu_pkg::bcd_sum_dword_op;
  localparam bcdmu_pkg::bcdmu_op_t WS = bcdmu_pkg::bcd_difference_word_op;
  localparam bcdmu_pkg::bcdmu_op_t DS = bcdmu_pkg::bcd_difference_dword_op;

  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 op_valid = 1'b0;
  bcdmu_pkg::bcdmu_op_t op_code = WC;
  logic                 op_use_imm = 1'b0;
  logic [15:0]          op_mem_lo = 16'h0;
  logic [15:0]          op_mem_hi = 16'h0;
  logic [31:0]          op_imm = 32'h0;
  logic                 op_ready;
  logic                 op_done;
  logic [31:0]          acc;
  logic [9:0]           flags;
  logic                 irq;
  int                   n_errors = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;
  int                   waits_exp = 0;

  bcdmu_top i_bcdmu_top (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_code(op_code), .op_use_imm(op_use_imm), .op_mem_lo(op_mem_lo),
    .op_mem_hi(op_mem_hi), .op_imm(op_imm), .op_ready(op_ready),
    .op_done(op_done), .acc(acc), .flags(flags), .irq(irq)
  );

  always #4 clock = ~clock;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one apb transfer; on a read d is the expected data
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // pready, pslverr and read data are taken at the completing edge
    while (pready !== 1'b1) begin
      n++;
      @(posedge clock);
    end
    chk32("pready_waits", waits_exp, n);
    chk1("pslverr", |{a[7:4], a[1:0]}, pslverr);
    if (!w) begin
      chk32("prdata", d, prdata);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one instruction; operand not selected gets the inverse pattern
  task automatic op(input bcdmu_pkg::bcdmu_op_t c, input logic im,
                    input logic [31:0] v, input logic [31:0] ea,
                    input logic [9:0] ef);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_use_imm <= im;
    op_imm <= im ? v : ~v;
    op_mem_hi <= im ? ~v[31:16] : v[31:16];
    op_mem_lo <= im ? ~v[15:0] : v[15:0];
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk1("op_done", 1'b1, op_done);
    chk1("op_ready", 1'b1, op_ready);
    chk32("acc", ea, acc);
    chk32("flags", {22'h0, ef}, {22'h0, flags});
    @(posedge clock);
    #1;
    chk1("op_done_low", 1'b0, op_done);
  endtask

  task automatic irq_is(input logic e);
    #1;
    chk1("irq", e, irq);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(0, AO, 32'h0);
    bus(0, FO, 32'h0);
    bus(0, SO, 32'h0);
    bus(0, MO, 32'h0);
    bus(1, 8'h10, 32'hffff_ffff);
    bus(0, 8'h10, 32'h0);
    $display("test reset done");
    bus(1, AO, 32'h0001_4526);
    op(WC, 0, 32'h0000_4527, 32'h0001_4526, LT);
    op(WC, 1, 32'hffff_bad9, 32'h0001_4526, EQ);
    op(WC, 0, 32'h0000_4525, 32'h0001_4526, GT);
    op(DC, 1, 32'h0001_4527, 32'h0001_4526, LT);
    op(DC, 0, 32'h0001_4526, 32'h0001_4526, EQ);
    op(DC, 1, 32'h0000_0000, 32'h0001_4526, GT);
    $display("test compare done");
    bus(1, AO, 32'h0000_5678);
    op(WA, 0, 32'h4444, 32'h0000_0122, GT|CW);
    op(WA, 0, 32'h0000_9878, 32'h0, GT | CW | ZR);
    bus(1, AO, 32'h9999_9999);
    op(DA, 1, 32'h0000_0001, 32'h0, GT | CW | CD | ZR);
    $display("test add done");
    bus(1, AO, 32'h0000_0100);
    op(WS, 0, 32'h0000_0200, 32'h9900, GT|CW|CD|BW);
    bus(1, AO, 32'h0);
    op(DS, 0, 32'h1, 32'h9999_9999, GT|CW|CD|BW|BD|NG);
    $display("test subtract done");
    op(DA, 1, 32'ha, 32'h9999_9999, GT|CW|BW|BD|NG|BAD);
    op(WA, 0, 32'h1, 32'h0, GT | CW | ZR | BW | BD);
    bus(1, FO, 32'h0000_03ff);
    bus(0, FO, {22'h0, GT | CW | ZR | BW | BD});
    bus(0, AO, 32'h0);
    $display("test digits done");
    // an accumulator write in its access phase waits for the instruction
    waits_exp = 1;
    fork
      bus(1, AO, 32'h0000_1234);
      begin
        @(posedge clock);
        op(WA, 0, 32'h1, 32'h1, GT | BW | BD);
      end
    join
    waits_exp = 0;
    bus(0, AO, 32'h0000_1234);
    $display("test stall done");
    bus(0, SO, 32'h7);
    irq_is(1'b0);
    bus(1, MO, 32'h2);
    irq_is(1'b1);
    bus(1, SO, 32'h2);
    irq_is(1'b0);
    bus(0, SO, 32'h5);
    bus(0, MO, 32'h2);
    bus(1, MO, 32'h5);
    irq_is(1'b1);
    bus(1, SO, 32'h5);
    irq_is(1'b0);
    bus(0, SO, 32'h0);
    $display("test interrupt done");
    close_out();
  end
endmodule

// file: verilog/bcdmu_alu_if.sv
// bcdmu_alu_if: operands and results between the core and the digit adder
// assumes: purely combinational traffic, no clock of its own
`timescale 1ns/1ps
interface bcdmu_alu_if;
  logic [31:0] a;
  logic [31:0] b;
  logic        sub;
  logic [31:0] sum;
  logic [8:0]  carry;
  logic        bad;

  modport core (output a, b, sub, input sum, carry, bad);
  modport alu  (input a, b, sub, output sum, carry, bad);
endinterface

// file: verilog/bcdmu_bcd_alu.sv
// bcdmu_bcd_alu: eight digit decimal adder and subtractor
// assumes: driven by the core through bcdmu_alu_if, result used same cycle
`timescale 1ns/1ps
module bcdmu_bcd_alu #(
  parameter int NDIG = 8
) (
  // operand and result bundle
  bcdmu_alu_if.alu port_if
);

  function automatic logic nib_bad(input logic [3:0] n);
    nib_bad = n > 4'h9;
  endfunction

  wire [NDIG:0]     cy;
  wire [4*NDIG-1:0] sum_w;
  wire [NDIG-1:0]   bad_w;

  // subtract is nines complement plus one carried in
  assign cy[0] = port_if.sub;

  genvar gi;
  generate
    for (gi = 0; gi < NDIG; gi++) begin : g_dig
      wire [3:0] ad  = port_if.a[4*gi +: 4];
      wire [3:0] bd  = port_if.b[4*gi +: 4];
      wire [3:0] bx  = port_if.sub ? 4'h9 - bd : bd;
      wire [4:0] raw = {1'b0, ad} + {1'b0, bx} + {4'h0, cy[gi]};
      wire       dc  = raw > 5'h09;
      wire [4:0] adj = raw + 5'h06;
      assign sum_w[4*gi +: 4] = dc ? adj[3:0] : raw[3:0];
      assign cy[gi+1] = dc;
      assign bad_w[gi] = nib_bad(ad) | nib_bad(bd);
    end
  endgenerate

  assign port_if.sum   = sum_w;
  assign port_if.carry = cy;
  assign port_if.bad   = |bad_w;

endmodule

// file: verilog/bcdmu_cfg.svh
// bcdmu_cfg.svh: register offsets, flag and event positions, reset values
// assumes: included by the bcd math unit design files
`ifndef BCDMU_CFG_SVH
`define BCDMU_CFG_SVH

`define BCDMU_ACC_OFS   8'h00
`define BCDMU_FLAG_OFS  8'h04
`define BCDMU_STAT_OFS  8'h08
`define BCDMU_MASK_OFS  8'h0c

`define BCDMU_F_LT      0
`define BCDMU_F_EQ      1
`define BCDMU_F_GT      2
`define BCDMU_F_ZERO    3
`define BCDMU_F_CY_W    4
`define BCDMU_F_CY_D    5
`define BCDMU_F_BR_W    6
`define BCDMU_F_BR_D    7
`define BCDMU_F_NEG     8
`define BCDMU_F_BAD     9
`define BCDMU_NFLAGS    10

`define BCDMU_EV_DONE   0
`define BCDMU_EV_BAD    1
`define BCDMU_EV_OVF    2
`define BCDMU_NEV       3

`define BCDMU_ACC_RST   32'h0000_0000
`define BCDMU_FLAG_RST  10'h000
`define BCDMU_EV_RST    3'h0

`endif

// file: verilog/bcdmu_pkg.sv
// bcdmu_pkg: types shared by the bcd math unit
// assumes: nothing beyond a SystemVerilog compiler
package bcdmu_pkg;

  typedef enum logic [2:0] {
    word_relation_op,
    dword_relation_op,
    bcd_sum_word_op,
    bcd_sum_dword_op,
    bcd_difference_word_op,
    bcd_difference_dword_op
  } bcdmu_op_t;

endpackage

// file: verilog/bcdmu_top.sv
// bcdmu_top: accumulator compare and bcd add/subtract unit with apb regs
// assumes: one clock, apb master of the same clock, sequencer hands in
// operands already fetched from word memory
`timescale 1ns/1ps
`include "bcdmu_cfg.svh"
module bcdmu_top (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // instruction port from the sequencer
  input  wire logic               op_valid,
  input  wire bcdmu_pkg::bcdmu_op_t op_code,
  input  wire logic               op_use_imm,
  input  wire logic [15:0]        op_mem_lo,
  input  wire logic [15:0]        op_mem_hi,
  input  wire logic [31:0]        op_imm,
  output logic                    op_ready,
  output logic                    op_done,
  // results
  output logic [31:0]             acc,
  output logic [`BCDMU_NFLAGS-1:0] flags,
  output logic                    irq
);

  logic [31:0]              acc_q;
  logic [31:0]              acc_d;
  logic [`BCDMU_NFLAGS-1:0] flags_q;
  logic [`BCDMU_NFLAGS-1:0] flags_d;
  logic [`BCDMU_NEV-1:0]    stat_q;
  logic [`BCDMU_NEV-1:0]    stat_d;
  logic [`BCDMU_NEV-1:0]    mask_q;
  logic [`BCDMU_NEV-1:0]    mask_d;
  logic [31:0]              prdata_q;
  logic                     done_q;

  bcdmu_alu_if alu_if ();

  bcdmu_bcd_alu #(
    .NDIG    (8)
  ) u_alu (
    .port_if (alu_if.alu)
  );

  // instruction decode
  wire take     = op_valid;
  wire is_wcmp  = op_code == bcdmu_pkg::word_relation_op;
  wire is_dcmp  = op_code == bcdmu_pkg::dword_relation_op;
  wire is_cmp   = is_wcmp | is_dcmp;
  wire is_sub   = op_code == bcdmu_pkg::bcd_difference_word_op
                | op_code == bcdmu_pkg::bcd_difference_dword_op;
  wire is_dw    = op_code == bcdmu_pkg::dword_relation_op
                | op_code == bcdmu_pkg::bcd_sum_dword_op
                | op_code == bcdmu_pkg::bcd_difference_dword_op;
  wire is_arith = ~is_cmp;
  wire take_ar  = take & is_arith;

  // operand selection
  wire [31:0] opnd_dw  = op_use_imm ? op_imm : {op_mem_hi, op_mem_lo};
  wire [31:0] opnd     = is_dw ? opnd_dw : {16'h0000, op_mem_lo};
  wire [31:0] acc_sel  = is_dw ? acc_q : {16'h0000, acc_q[15:0]};

  assign alu_if.a   = acc_sel;
  assign alu_if.b   = opnd;
  assign alu_if.sub = is_sub;

  // relation of accumulator to operand
  wire cmp_lt = acc_sel < opnd;
  wire cmp_eq = acc_sel == opnd;
  wire cmp_gt = acc_sel > opnd;

  // arithmetic result; a non-decimal operand leaves the accumulator
  wire        bad    = alu_if.bad;
  wire [31:0] sum_w  = {16'h0000, alu_if.sum[15:0]};
  wire [31:0] res    = bad ? acc_q : (is_dw ? alu_if.sum : sum_w);
  wire        cy_w   = alu_if.carry[4];
  wire        cy_d   = alu_if.carry[8];
  wire        cy_sel = is_dw ? cy_d : cy_w;
  wire        ovf    = ~bad & (is_sub ? ~cy_sel : cy_sel);

  // apb decode
  wire hit_acc  = paddr == `BCDMU_ACC_OFS;
  wire hit_flag = paddr == `BCDMU_FLAG_OFS;
  wire hit_stat = paddr == `BCDMU_STAT_OFS;
  wire hit_mask = paddr == `BCDMU_MASK_OFS;
  wire hit      = hit_acc | hit_flag | hit_stat | hit_mask;
  wire setup    = psel & ~penable;
  // an accumulator write waits while op_valid presents any instruction, compare included
  wire stall    = op_valid & pwrite & hit_acc;
  wire access   = psel & penable & ~stall;
  wire wr       = access & pwrite & hit;
  wire [31:0] rd_mux =
      hit_acc  ? acc_q :
      hit_flag ? {22'h000000, flags_q} :
      hit_stat ? {29'h00000000, stat_q} :
      hit_mask ? {29'h00000000, mask_q} : 32'h0000_0000;

  // accumulator next value
  always_comb begin
    acc_d = acc_q;
    if (take_ar) begin
      acc_d = res;
    end else if (wr & hit_acc) begin
      acc_d = pwdata;
    end
  end

  // flags: only the flags an instruction owns are rewritten
  always_comb begin
    flags_d = flags_q;
    if (take & is_cmp) begin
      flags_d[`BCDMU_F_LT] = cmp_lt;
      flags_d[`BCDMU_F_EQ] = cmp_eq;
      flags_d[`BCDMU_F_GT] = cmp_gt;
    end else if (take_ar) begin
      flags_d[`BCDMU_F_ZERO] = res == 32'h0000_0000;
      flags_d[`BCDMU_F_NEG]  = res[31];
      flags_d[`BCDMU_F_BAD]  = bad;
      case ({is_sub, is_dw})
        2'b00: flags_d[`BCDMU_F_CY_W] = ovf;
        2'b01: flags_d[`BCDMU_F_CY_D] = ovf;
        2'b10: flags_d[`BCDMU_F_BR_W] = ovf;
        2'b11: flags_d[`BCDMU_F_BR_D] = ovf;
        default: flags_d = flags_q;
      endcase
    end
  end

  // sticky events, set wins over a one written to clear
  wire [`BCDMU_NEV-1:0] ev = {take_ar & ovf, take_ar & bad, take};
  wire [`BCDMU_NEV-1:0] w1c =
      (wr & hit_stat) ? pwdata[`BCDMU_NEV-1:0] : `BCDMU_EV_RST;
  assign stat_d = (stat_q & ~w1c) | ev;
  assign mask_d = (wr & hit_mask) ? pwdata[`BCDMU_NEV-1:0] : mask_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q   <= `BCDMU_ACC_RST;
      flags_q <= `BCDMU_FLAG_RST;
      stat_q  <= `BCDMU_EV_RST;
      mask_q  <= `BCDMU_EV_RST;
    end else begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      done_q   <= 1'b0;
    end else begin
      prdata_q <= setup ? rd_mux : prdata_q;
      done_q   <= take;
    end
  end

  assign prdata   = prdata_q;
  assign pready   = ~stall;
  assign pslverr  = psel & penable & ~hit;
  assign op_ready = 1'b1;
  assign op_done  = done_q;
  assign acc      = acc_q;
  assign flags    = flags_q;
  assign irq      = |(stat_q & mask_q);

  // checks
  function automatic logic all_dec(input logic [31:0] v);
    all_dec = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (v[4*i +: 4] > 4'h9) begin
        all_dec = 1'b0;
      end
    end
  endfunction

  logic [31:0] chk_opnd_q;
  logic [31:0] chk_sum_q;
  logic [31:0] chk_acc_q;
  always_ff @(posedge clock) begin
    chk_opnd_q <= opnd;
    chk_sum_q  <= alu_if.sum;
    chk_acc_q  <= acc_sel;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_wcmp;
    take && is_wcmp;
  endsequence
  sequence s_cmp;
    take && is_cmp;
  endsequence
  sequence s_good_ar;
    take_ar && !bad;
  endsequence

  property p_one_rel;
    s_wcmp |=> $onehot(flags_q[2:0]) && op_done;
  endproperty
  a_one_rel: assert property (p_one_rel)
    else $error("word compare did not give one relation flag");

  property p_lt;
    s_cmp |=> flags_q[`BCDMU_F_LT] == (chk_acc_q < chk_opnd_q);
  endproperty
  a_lt: assert property (p_lt)
    else $error("less flag wrong after compare");

  property p_eq;
    s_cmp |=> flags_q[`BCDMU_F_EQ] == (chk_acc_q == chk_opnd_q);
  endproperty
  a_eq: assert property (p_eq)
    else $error("equal flag wrong after compare");

  property p_gt;
    s_cmp |=> flags_q[`BCDMU_F_GT] == (chk_acc_q > chk_opnd_q);
  endproperty
  a_gt: assert property (p_gt)
    else $error("greater flag wrong after compare");

  property p_dcmp_imm;
    take && is_dcmp && op_use_imm && acc_q == op_imm
      |=> flags_q[`BCDMU_F_EQ] && !flags_q[`BCDMU_F_LT];
  endproperty
  a_dcmp_imm: assert property (p_dcmp_imm)
    else $error("double compare with constant missed equality");

  property p_hold;
    !(take && is_cmp) |=> $stable(flags_q[2:0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("relation flags changed without a compare");

  property p_sum;
    s_good_ar |=> acc_q == chk_sum_q
      || (acc_q[31:16] == 16'h0000 && acc_q[15:0] == chk_sum_q[15:0]);
  endproperty
  a_sum: assert property (p_sum)
    else $error("accumulator did not take the bcd result");

  property p_zero;
    take_ar |=> flags_q[`BCDMU_F_ZERO] == (acc_q == 32'h0000_0000);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag does not match accumulator");

  property p_cy_w;
    take && op_code == bcdmu_pkg::bcd_sum_word_op && !bad
      |=> flags_q[`BCDMU_F_CY_W] == $past(cy_w);
  endproperty
  a_cy_w: assert property (p_cy_w)
    else $error("word carry flag wrong");

  property p_neg;
    take_ar |=> flags_q[`BCDMU_F_NEG] == acc_q[31];
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative flag does not match accumulator");

  property p_bad;
    take_ar && bad |=> flags_q[`BCDMU_F_BAD] && stat_q[`BCDMU_EV_BAD]
      && acc_q == $past(acc_q);
  endproperty
  a_bad: assert property (p_bad)
    else $error("non-decimal operand not flagged or acc changed");

  property p_dsub;
    take && op_code == bcdmu_pkg::bcd_difference_dword_op && !bad
      |=> flags_q[`BCDMU_F_BR_D] == !$past(cy_d);
  endproperty
  a_dsub: assert property (p_dsub)
    else $error("double borrow flag wrong");

  property p_digits;
    s_good_ar |=> all_dec(acc_q);
  endproperty
  a_digits: assert property (p_digits)
    else $error("accumulator holds a non-decimal digit after bcd op");

  property p_cy_d;
    take && op_code == bcdmu_pkg::bcd_sum_dword_op && !bad
      |=> flags_q[`BCDMU_F_CY_D] == $past(cy_d);
  endproperty
  a_cy_d: assert property (p_cy_d)
    else $error("double carry flag wrong");

  property p_br_w;
    take && op_code == bcdmu_pkg::bcd_difference_word_op && !bad
      |=> flags_q[`BCDMU_F_BR_W] == !$past(cy_w);
  endproperty
  a_br_w: assert property (p_br_w)
    else $error("word borrow flag wrong");

  property p_word_hi;
    take_ar && !bad && !is_dw |=> acc_q[31:16] == 16'h0000;
  endproperty
  a_word_hi: assert property (p_word_hi)
    else $error("word bcd op left a non-zero upper half");

  property p_cmp_acc;
    s_cmp |=> acc_q == $past(acc_q);
  endproperty
  a_cmp_acc: assert property (p_cmp_acc)
    else $error("compare changed the accumulator");

  property p_cmp_keep;
    s_cmp |=> flags_q[9:3] == $past(flags_q[9:3]);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep)
    else $error("compare changed an arithmetic flag");

endmodule
